// ### rtl/mch_pkg.sv
// Shared types and constants of the common command handler
package mch_pkg;

    // Standard event status bit positions and power-on value
    localparam int unsigned POWER_ON_BIT      = 7;
    localparam int unsigned COMMAND_ERROR_BIT = 5;
    localparam int unsigned EXEC_ERROR_BIT    = 4;
    localparam int unsigned DEVICE_ERROR_BIT  = 3;
    localparam int unsigned QUERY_ERROR_BIT   = 2;
    localparam logic [7:0]  EVENT_RESET       = 8'h80;
    localparam logic [7:0]  EVENT_USED_MASK   = 8'hBC;

    // Self test result fields
    localparam logic [3:0]  SELF_TEST_MASK    = 4'hF;

    // Response sizing
    localparam int unsigned MAX_RESPONSE_BYTES = 300;
    localparam int unsigned MAX_NUMBER_BYTES   = 3;
    localparam int unsigned ON_OFF_BYTES       = 3;

    // Averaging and setting defaults
    localparam logic [6:0]  AVERAGE_OFF        = 7'h00;
    localparam logic [6:0]  AVERAGE_MAX        = 7'h40;
    localparam logic        BACKLIGHT_DEFAULT  = 1'b1;
    localparam logic        MONITOR_DEFAULT    = 1'b1;

    // Backlight blank delay
    localparam int unsigned CLOCK_HZ           = 100_000_000;
    localparam int unsigned BLANK_DELAY_S      = 10;
    localparam int unsigned BLANK_DELAY_CYCLES = BLANK_DELAY_S * CLOCK_HZ;

    typedef enum logic [3:0] {
        OP_CLEAR_STATUS, OP_EVENT_QUERY, OP_IDENT_QUERY, OP_RESET, OP_TRIGGER,
        OP_SELF_TEST, OP_WAIT, OP_BACKLIGHT, OP_BACKLIGHT_QUERY, OP_MONITOR,
        OP_MONITOR_QUERY, OP_AVERAGE, OP_AVERAGE_QUERY, OP_READ_RESULT, OP_SETTING
    } mch_op_t;

    typedef enum logic [2:0] {
        ARG_NONE, ARG_ON, ARG_OFF, ARG_NUMBER, ARG_OTHER
    } mch_arg_t;

    typedef enum logic [1:0] {
        RESP_INTEGER, RESP_ON, RESP_OFF, RESP_IDENT
    } mch_resp_kind_t;

    typedef struct packed {
        mch_op_t    opcode;
        mch_arg_t   argKind;
        logic [15:0] argValue;
        logic       argRoundUp;
    } mch_cmd_t;

    typedef struct packed {
        mch_resp_kind_t kind;
        logic [7:0]     value;
        logic           header;
    } mch_resp_t;

endpackage : mch_pkg

// ### rtl/mch_command_handler.sv
// Common and display command execution for the remote-control port
`timescale 1ns/1ns
`default_nettype none
module mch_command_handler
    import mch_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES = BLANK_DELAY_CYCLES,
    parameter int unsigned IDENT_BYTES  = 20,
    parameter int unsigned HEADER_BYTES = 24
) (
    input  wire logic          clock,
    input  wire logic          reset,
    input  wire logic          cmdValid,
    input  wire mch_pkg::mch_cmd_t cmdWord,
    input  wire logic          cmdHasData,
    output logic               cmdReady,
    input  wire logic          headerEnable,
    input  wire logic          triggerExternal,
    input  wire logic          compensationBusy,
    input  wire logic          engineBusy,
    input  wire logic          selfTestDone,
    input  wire logic [3:0]    selfTestFaults,
    input  wire logic          touchPanel,
    input  wire logic [7:0]    deviceEventA,
    input  wire logic [7:0]    deviceEventB,
    input  wire logic          deviceError,
    output logic               respValid,
    output mch_pkg::mch_resp_t respWord,
    output logic [7:0]         standardEventStatus,
    output logic [7:0]         deviceEventStatusA,
    output logic [7:0]         deviceEventStatusB,
    output logic               measureStart,
    output logic               readResultStart,
    output logic               selfTestStart,
    output logic               settingStrobe,
    output logic               defaultsLoad,
    output logic               displayLit,
    output logic               monitorShown,
    output logic [6:0]         averageCount
);
    import mch_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SELF_TEST} mch_state_t;

    mch_state_t  state_q, state_d;
    logic        ready_q;
    logic [7:0]  standard_event_status_q, standard_event_status_d;
    logic [7:0]  evtA_q, evtB_q;
    mch_resp_t   resp_q, resp_d;
    logic        respValid_q, respValid_d;
    logic        read_result_query_q, readResult_q, selfTest_q, setting_q, defaults_q;
    logic        backlightOn_q, backlightOn_d;
    logic        monitor_q, monitor_d;
    logic [6:0]  average_q, average_d;
    logic [31:0] blank_q, blank_d;
    logic        lit_q;

    wire mch_cmd_t cmd       = cmdWord;
    wire logic     take      = cmdValid && ready_q;
    wire logic     isOp      [0:14];
    wire logic     noParam   = isOp[OP_CLEAR_STATUS] || isOp[OP_RESET]
                               || isOp[OP_TRIGGER] || isOp[OP_WAIT];
    wire logic     needsIdle = isOp[OP_TRIGGER] || isOp[OP_SELF_TEST] || isOp[OP_BACKLIGHT]
                               || isOp[OP_MONITOR] || isOp[OP_AVERAGE] || isOp[OP_SETTING];
    wire logic     onOffArg  = (cmd.argKind == ARG_ON) || (cmd.argKind == ARG_OFF);
    wire logic [16:0] rounded = {1'b0, cmd.argValue} + {16'h0000, cmd.argRoundUp};
    wire logic     avgPow2   = (rounded == 17'h00002) || (rounded == 17'h00004)
                               || (rounded == 17'h00008) || (rounded == 17'h00010)
                               || (rounded == 17'h00020) || (rounded == 17'h00040);
    wire logic     avgValid  = (cmd.argKind == ARG_OFF) || ((cmd.argKind == ARG_NUMBER) && avgPow2);

    genvar g;
    generate
        for (g = 0; g < 15; g++) begin : gDecode
            assign isOp[g] = take && (cmd.opcode == mch_op_t'(g));
        end
    endgenerate

    // Error sources, evaluated in priority order for one command
    wire logic cmdErr   = (noParam && cmdHasData)
                          || (isOp[OP_AVERAGE] && !compensationBusy && !avgValid);
    wire logic execBusy = needsIdle && compensationBusy && !(noParam && cmdHasData);
    wire logic execTrig = isOp[OP_TRIGGER] && !cmdHasData && !compensationBusy
                          && !triggerExternal;
    wire logic execArg  = (isOp[OP_BACKLIGHT] || isOp[OP_MONITOR]) && !compensationBusy
                          && !onOffArg;
    wire logic execErr  = execBusy || execTrig || execArg;
    wire logic goodCmd  = take && !cmdErr && !execErr;

    // Response length check; setting and averaging answers grow by the header when headerEnable is set
    wire logic [15:0] hdrLen   = headerEnable ? 16'(HEADER_BYTES) : 16'h0000;
    wire logic        longId   = isOp[OP_IDENT_QUERY] && (IDENT_BYTES > MAX_RESPONSE_BYTES);
    wire logic        longSet  = (isOp[OP_BACKLIGHT_QUERY] || isOp[OP_MONITOR_QUERY])
                                 && ((32'(hdrLen) + ON_OFF_BYTES) > MAX_RESPONSE_BYTES);
    wire logic        longAvg  = isOp[OP_AVERAGE_QUERY]
                                 && ((32'(hdrLen) + MAX_NUMBER_BYTES) > MAX_RESPONSE_BYTES);
    wire logic        queryErr = longId || longSet || longAvg;
    wire logic        testLong = (MAX_NUMBER_BYTES > MAX_RESPONSE_BYTES);

    wire logic [7:0] setBits = ({7'h00, cmdErr} << COMMAND_ERROR_BIT)
                               | ({7'h00, execErr} << EXEC_ERROR_BIT)
                               | ({7'h00, deviceError} << DEVICE_ERROR_BIT)
                               | ({7'h00, queryErr} << QUERY_ERROR_BIT);

    always_comb begin
        state_d       = state_q;
        standard_event_status_d        = standard_event_status_q;
        resp_d        = resp_q;
        respValid_d   = 1'b0;
        backlightOn_d = backlightOn_q;
        monitor_d     = monitor_q;
        average_d     = average_q;
        blank_d       = (blank_q != 32'h00000000) ? blank_q - 32'h00000001 : blank_q;
        if (touchPanel) begin
            blank_d = BLANK_CYCLES;
        end
        case (state_q)
            ST_IDLE: begin
                if (isOp[OP_CLEAR_STATUS] && goodCmd) begin
                    standard_event_status_d = 8'h00;
                end
                if (isOp[OP_EVENT_QUERY]) begin
                    resp_d      = '{kind: RESP_INTEGER, value: standard_event_status_q, header: 1'b0};
                    respValid_d = 1'b1;
                    standard_event_status_d      = 8'h00;
                end
                if (isOp[OP_IDENT_QUERY] && !longId) begin
                    resp_d      = '{kind: RESP_IDENT, value: 8'h00, header: 1'b0};
                    respValid_d = 1'b1;
                end
                if (isOp[OP_RESET] && goodCmd) begin
                    backlightOn_d = BACKLIGHT_DEFAULT;
                    monitor_d     = MONITOR_DEFAULT;
                    average_d     = AVERAGE_OFF;
                end
                if (isOp[OP_SELF_TEST] && goodCmd) begin
                    state_d = ST_SELF_TEST;
                end
                if (isOp[OP_WAIT] && goodCmd && engineBusy) begin
                    state_d = ST_WAIT;
                end
                if (isOp[OP_BACKLIGHT] && goodCmd) begin
                    backlightOn_d = (cmd.argKind == ARG_ON);
                    blank_d       = BLANK_CYCLES;
                end
                if (isOp[OP_MONITOR] && goodCmd) begin
                    monitor_d = (cmd.argKind == ARG_ON);
                end
                if (isOp[OP_AVERAGE] && goodCmd) begin
                    average_d = (cmd.argKind == ARG_OFF) ? AVERAGE_OFF : rounded[6:0];
                end
                if ((isOp[OP_BACKLIGHT_QUERY] || isOp[OP_MONITOR_QUERY]) && !longSet) begin
                    resp_d.kind   = (isOp[OP_BACKLIGHT_QUERY] ? backlightOn_q : monitor_q)
                                    ? RESP_ON : RESP_OFF;
                    resp_d.value  = 8'h00;
                    resp_d.header = headerEnable;
                    respValid_d   = 1'b1;
                end
                if (isOp[OP_AVERAGE_QUERY] && !longAvg) begin
                    resp_d      = '{kind: (average_q == AVERAGE_OFF) ? RESP_OFF : RESP_INTEGER,
                                    value: {1'b0, average_q}, header: headerEnable};
                    respValid_d = 1'b1;
                end
            end
            ST_WAIT: begin
                if (!engineBusy) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SELF_TEST: begin
                if (selfTestDone) begin
                    state_d = ST_IDLE;
                    if (!testLong) begin
                        resp_d      = '{kind: RESP_INTEGER,
                                        value: {4'h0, selfTestFaults & SELF_TEST_MASK},
                                        header: 1'b0};
                        respValid_d = 1'b1;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // New errors win over a clear in the same cycle
        standard_event_status_d = (standard_event_status_d | setBits) & EVENT_USED_MASK;
        if (state_q == ST_SELF_TEST && selfTestDone && testLong) begin
            standard_event_status_d[QUERY_ERROR_BIT] = 1'b1;
        end
    end

    wire logic clearDev = isOp[OP_CLEAR_STATUS] && goodCmd;

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b0;
            standard_event_status_q  <= EVENT_RESET;
            evtA_q  <= 8'h00;
            evtB_q  <= 8'h00;
        end else begin
            state_q <= state_d;
            // One command at a time, none while waiting or testing
            ready_q <= (state_d == ST_IDLE) && !take;
            standard_event_status_q  <= standard_event_status_d;
            evtA_q  <= (clearDev ? 8'h00 : evtA_q) | deviceEventA;
            evtB_q  <= (clearDev ? 8'h00 : evtB_q) | deviceEventB;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            resp_q       <= '{kind: RESP_INTEGER, value: 8'h00, header: 1'b0};
            respValid_q  <= 1'b0;
            read_result_query_q    <= 1'b0;
            readResult_q <= 1'b0;
            selfTest_q   <= 1'b0;
            setting_q    <= 1'b0;
            defaults_q   <= 1'b0;
        end else begin
            resp_q       <= resp_d;
            respValid_q  <= respValid_d;
            read_result_query_q    <= isOp[OP_TRIGGER] && goodCmd;
            readResult_q <= isOp[OP_READ_RESULT];
            selfTest_q   <= isOp[OP_SELF_TEST] && goodCmd;
            setting_q    <= isOp[OP_SETTING] && goodCmd;
            defaults_q   <= isOp[OP_RESET] && goodCmd;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            backlightOn_q <= BACKLIGHT_DEFAULT;
            monitor_q     <= MONITOR_DEFAULT;
            average_q     <= AVERAGE_OFF;
            blank_q       <= BLANK_CYCLES;
            lit_q         <= 1'b1;
        end else begin
            backlightOn_q <= backlightOn_d;
            monitor_q     <= monitor_d;
            average_q     <= average_d;
            blank_q       <= blank_d;
            // Timer of one stays lit so the blank lands on expiry
            lit_q         <= backlightOn_d || (blank_d != 32'h00000000);
        end
    end

    assign cmdReady            = ready_q;
    assign respValid           = respValid_q;
    assign respWord            = resp_q;
    assign standardEventStatus = standard_event_status_q;
    assign deviceEventStatusA  = evtA_q;
    assign deviceEventStatusB  = evtB_q;
    assign measureStart        = read_result_query_q;
    assign readResultStart     = readResult_q;
    assign selfTestStart       = selfTest_q;
    assign settingStrobe       = setting_q;
    assign defaultsLoad        = defaults_q;
    assign displayLit          = lit_q;
    assign monitorShown        = monitor_q;
    assign averageCount        = average_q;

    a_param_data_error: assert property (@(posedge clock) disable iff (reset)
        (take && noParam && cmdHasData) |=> standardEventStatus[COMMAND_ERROR_BIT])
        else $error("Data after parameterless command not flagged");
    a_event_read_clear: assert property (@(posedge clock) disable iff (reset)
        (isOp[OP_EVENT_QUERY] && !cmdErr && !execErr && !deviceError)
        |=> respValid && respWord.value == $past(standard_event_status_q) && standardEventStatus == 8'h00)
        else $error("Event query did not return and clear");
    a_no_header_event: assert property (@(posedge clock) disable iff (reset)
        (take && (cmd.opcode == OP_EVENT_QUERY || cmd.opcode == OP_IDENT_QUERY))
        |=> respValid && !respWord.header)
        else $error("Header on common query answer");
    a_trigger_once: assert property (@(posedge clock) disable iff (reset)
        measureStart |-> !$past(measureStart) && $past(isOp[OP_TRIGGER] && triggerExternal))
        else $error("Trigger started more than one measurement");
    a_trigger_internal: assert property (@(posedge clock) disable iff (reset)
        (isOp[OP_TRIGGER] && !triggerExternal && !cmdHasData)
        |=> !measureStart && standardEventStatus[EXEC_ERROR_BIT])
        else $error("Trigger accepted in internal mode");
    a_busy_refuse: assert property (@(posedge clock) disable iff (reset)
        (take && needsIdle && compensationBusy && !cmdHasData)
        |=> !settingStrobe && !selfTestStart && standardEventStatus[EXEC_ERROR_BIT])
        else $error("Command not refused during compensation");
    a_wait_holds: assert property (@(posedge clock) disable iff (reset)
        (state_q == ST_WAIT && engineBusy) |=> !cmdReady)
        else $error("Commands taken while waiting");
    a_selftest_range: assert property (@(posedge clock) disable iff (reset)
        (state_q == ST_SELF_TEST && selfTestDone) |=> respValid && respWord.value <= 8'h0F
        && respWord.value[3:0] == $past(selfTestFaults) && !respWord.header)
        else $error("Self test answer out of range");
    a_average_set: assert property (@(posedge clock) disable iff (reset)
        (isOp[OP_AVERAGE] && goodCmd && cmd.argKind == ARG_NUMBER) |=> averageCount <= AVERAGE_MAX
        && averageCount == $past(rounded[6:0]))
        else $error("Averaging count not stored");
    a_average_bad: assert property (@(posedge clock) disable iff (reset)
        (isOp[OP_AVERAGE] && !avgValid && !compensationBusy)
        |=> standardEventStatus[COMMAND_ERROR_BIT] && $stable(averageCount))
        else $error("Bad averaging not a command error");
    a_light_arg: assert property (@(posedge clock) disable iff (reset)
        (isOp[OP_BACKLIGHT] && !onOffArg) |=> standardEventStatus[EXEC_ERROR_BIT])
        else $error("Bad backlight argument accepted");
    a_light_on: assert property (@(posedge clock) disable iff (reset)
        backlightOn_q |=> displayLit)
        else $error("Display dark with backlight on");
    a_clear_events: assert property (@(posedge clock) disable iff (reset)
        (isOp[OP_CLEAR_STATUS] && goodCmd && deviceEventA == 8'h00 && deviceEventB == 8'h00)
        |=> deviceEventStatusA == 8'h00 && deviceEventStatusB == 8'h00
        && !standardEventStatus[POWER_ON_BIT])
        else $error("Clear status left event bits set");
    a_result_nowait: assert property (@(posedge clock) disable iff (reset)
        isOp[OP_READ_RESULT] |=> readResultStart)
        else $error("Result query not started at once");
    a_setting_taken: assert property (@(posedge clock) disable iff (reset)
        (isOp[OP_SETTING] && !compensationBusy) |=> settingStrobe)
        else $error("Setting not passed on while idle");
    a_reset_defaults: assert property (@(posedge clock) disable iff (reset)
        (isOp[OP_RESET] && !cmdHasData)
        |=> defaultsLoad && displayLit && monitorShown && averageCount == AVERAGE_OFF)
        else $error("Reset command did not restore defaults");

endmodule : mch_command_handler
`default_nettype wire

// ### testbench/mch_host_model.sv
// Host side model feeding message units into the command port
`timescale 1ns/1ns
`default_nettype none
module mch_host_model
    import mch_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              cmdReady,
    output var  logic              cmdValid,
    output var  mch_pkg::mch_cmd_t cmdWord,
    output var  logic              cmdHasData
);
    initial begin
        cmdValid   = 1'b0;
        cmdWord    = '0;
        cmdHasData = 1'b0;
    end
    // Released lines are scrambled so a stale unit never looks valid
    task automatic send(input mch_op_t op, input mch_arg_t k, input logic [15:0] val,
                        input logic up, input logic data, input int gap);
        int n;
        n = 0;
        repeat (gap + 1) @(negedge clock);
        cmdValid   = 1'b1;
        cmdWord    = '{op, k, val, up};
        cmdHasData = data;
        while (cmdReady !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        cmdValid   = 1'b0;
        cmdWord    = mch_cmd_t'(~cmdWord);
        cmdHasData = ~data;
    endtask : send
endmodule : mch_host_model
`default_nettype wire

// ### testbench/mch_command_handler_test.sv
// Self-checking bench of the common command handler
`timescale 1ns/1ns
`default_nettype none
module mch_command_handler_test;
    import mch_pkg::*;
    localparam int unsigned BLANK = 20; // Short blank delay keeps the run brief
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        cmdValid, cmdHasData, cmdReady, respValid, up;
    mch_cmd_t    cmdWord;
    mch_resp_t   respWord;
    logic        headerEnable = 1'b0, triggerExternal = 1'b0, compensationBusy = 1'b0;
    logic        engineBusy = 1'b0, selfTestDone = 1'b0, touchPanel = 1'b0, deviceError = 1'b0;
    logic [3:0]  selfTestFaults = 4'h0;
    logic [7:0]  deviceEventA = 8'h00, deviceEventB = 8'h00, standardEventStatus;
    logic [7:0]  deviceEventStatusA, deviceEventStatusB;
    logic        measureStart, readResultStart, selfTestStart, settingStrobe, defaultsLoad;
    logic        displayLit, monitorShown;
    logic [6:0]  averageCount;
    logic [15:0] v;
    int          error_cnt = 0, compares = 0, seed;

    always #5 clock = ~clock;

    mch_command_handler #(.BLANK_CYCLES(BLANK)) u_dut (.clock, .reset, .cmdValid, .cmdWord,
        .cmdHasData, .cmdReady, .headerEnable, .triggerExternal, .compensationBusy,
        .engineBusy, .selfTestDone, .selfTestFaults, .touchPanel, .deviceEventA,
        .deviceEventB, .deviceError, .respValid, .respWord, .standardEventStatus,
        .deviceEventStatusA, .deviceEventStatusB, .measureStart, .readResultStart,
        .selfTestStart, .settingStrobe, .defaultsLoad, .displayLit, .monitorShown,
        .averageCount);
    mch_host_model u_host (.clock, .cmdReady, .cmdValid, .cmdWord, .cmdHasData);

    function automatic logic [7:0] bitOf(input int unsigned b);
        return 8'h01 << b;
    endfunction : bitOf

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cmd(input mch_op_t op, input mch_arg_t k, input logic [15:0] val);
        u_host.send(op, k, val, 1'b0, 1'b0, $urandom_range(2));
    endtask : cmd

    // Value is only defined for integer answers
    task automatic ask(input mch_op_t op, input mch_resp_kind_t k, input logic [7:0] val,
                       input logic hdr);
        cmd(op, ARG_NONE, 16'h0000);
        check({respValid, respWord.kind, respWord.header}, {1'b1, k, hdr});
        if (k == RESP_INTEGER)
            check(respWord.value, val);
    endtask : ask

    task automatic errCase(input mch_op_t op, input mch_arg_t k, input logic data,
                           input logic comp, input logic [7:0] exp);
        compensationBusy = comp;
        u_host.send(op, k, 16'h0003, 1'b0, data, 0);
        compensationBusy = 1'b0;
        ask(OP_EVENT_QUERY, RESP_INTEGER, exp, 1'b0);
    endtask : errCase

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    initial begin
        seed = $urandom(48400);
        repeat (5) @(negedge clock);
        reset = 1'b0;
        check(standardEventStatus, EVENT_RESET);
        check({displayLit, monitorShown, averageCount}, {2'b11, AVERAGE_OFF});
        headerEnable = 1'b1;
        ask(OP_EVENT_QUERY, RESP_INTEGER, EVENT_RESET, 1'b0);
        check(standardEventStatus, 8'h00);
        errCase(OP_TRIGGER, ARG_NONE, 1'b0, 1'b0, bitOf(EXEC_ERROR_BIT));
        errCase(OP_WAIT, ARG_NUMBER, 1'b1, 1'b0, bitOf(COMMAND_ERROR_BIT));
        errCase(OP_CLEAR_STATUS, ARG_NUMBER, 1'b1, 1'b0, bitOf(COMMAND_ERROR_BIT));
        errCase(OP_BACKLIGHT, ARG_OTHER, 1'b0, 1'b0, bitOf(EXEC_ERROR_BIT));
        errCase(OP_MONITOR, ARG_NUMBER, 1'b0, 1'b0, bitOf(EXEC_ERROR_BIT));
        errCase(OP_AVERAGE, ARG_NUMBER, 1'b0, 1'b0, bitOf(COMMAND_ERROR_BIT));
        errCase(OP_AVERAGE, ARG_OTHER, 1'b0, 1'b1, bitOf(EXEC_ERROR_BIT));
        errCase(OP_SETTING, ARG_NUMBER, 1'b0, 1'b1, bitOf(EXEC_ERROR_BIT));
        errCase(OP_SELF_TEST, ARG_NONE, 1'b0, 1'b1, bitOf(EXEC_ERROR_BIT));
        cmd(OP_SETTING, ARG_NUMBER, 16'h0003);
        check(settingStrobe, 1'b1);
        ask(OP_EVENT_QUERY, RESP_INTEGER, 8'h00, 1'b0);
        $display("errors test done");
        triggerExternal = 1'b1;
        cmd(OP_TRIGGER, ARG_NONE, 16'h0000);
        check(measureStart, 1'b1);
        @(negedge clock);
        check(measureStart, 1'b0);
        errCase(OP_TRIGGER, ARG_NUMBER, 1'b1, 1'b0, bitOf(COMMAND_ERROR_BIT));
        triggerExternal = 1'b0;
        v = 16'($urandom);
        deviceEventA = v[15:8];
        deviceEventB = v[7:0];
        deviceError = 1'b1;
        @(negedge clock);
        {deviceEventA, deviceEventB, deviceError} = 17'h00000;
        @(negedge clock);
        check({deviceEventStatusA, deviceEventStatusB}, v);
        check(standardEventStatus, bitOf(DEVICE_ERROR_BIT));
        cmd(OP_CLEAR_STATUS, ARG_NONE, 16'h0000);
        check({standardEventStatus, deviceEventStatusA, deviceEventStatusB}, 24'h0);
        $display("status test done");
        for (int i = 0; i < 6; i++) begin
            v = 16'h0002 << i;
            up = 1'($urandom_range(1));
            headerEnable = 1'($urandom_range(1));
            u_host.send(OP_AVERAGE, ARG_NUMBER, v - 16'(up), up, 1'b0, $urandom_range(3));
            check(averageCount, v[6:0]);
            ask(OP_AVERAGE_QUERY, RESP_INTEGER, v[7:0], headerEnable);
        end
        cmd(OP_MONITOR, ARG_OFF, 16'h0000);
        check(monitorShown, 1'b0);
        ask(OP_MONITOR_QUERY, RESP_OFF, 8'h00, headerEnable);
        cmd(OP_MONITOR, ARG_ON, 16'h0000);
        check(monitorShown, 1'b1);
        cmd(OP_MONITOR, ARG_OFF, 16'h0000);
        cmd(OP_BACKLIGHT, ARG_OFF, 16'h0000);
        ask(OP_BACKLIGHT_QUERY, RESP_OFF, 8'h00, headerEnable);
        touchPanel = 1'b1;
        @(negedge clock);
        touchPanel = 1'b0;
        repeat (BLANK / 2) @(negedge clock);
        check(displayLit, 1'b1);
        repeat (BLANK) @(negedge clock);
        check(displayLit, 1'b0);
        cmd(OP_BACKLIGHT, ARG_ON, 16'h0000);
        check(displayLit, 1'b1);
        cmd(OP_BACKLIGHT, ARG_OFF, 16'h0000);
        repeat (BLANK + 2) @(negedge clock);
        check(displayLit, 1'b0);
        cmd(OP_RESET, ARG_NONE, 16'h0000);
        check(defaultsLoad, 1'b1);
        @(negedge clock);
        check({displayLit, monitorShown, averageCount}, {2'b11, AVERAGE_OFF});
        ask(OP_AVERAGE_QUERY, RESP_OFF, 8'h00, headerEnable);
        ask(OP_BACKLIGHT_QUERY, RESP_ON, 8'h00, headerEnable);
        cmd(OP_AVERAGE, ARG_NUMBER, 16'h0008);
        check(averageCount, 7'h08);
        cmd(OP_AVERAGE, ARG_OFF, 16'h0000);
        check(averageCount, AVERAGE_OFF);
        $display("settings test done");
        headerEnable = 1'b1;
        v = 16'($urandom_range(15));
        cmd(OP_SELF_TEST, ARG_NONE, 16'h0000);
        check(selfTestStart, 1'b1);
        repeat (3) @(negedge clock);
        selfTestDone = 1'b1;
        selfTestFaults = v[3:0];
        @(negedge clock);
        selfTestDone = 1'b0;
        selfTestFaults = ~v[3:0];
        check({respValid, respWord}, {1'b1, RESP_INTEGER, v[7:0], 1'b0});
        ask(OP_IDENT_QUERY, RESP_IDENT, 8'h00, 1'b0);
        engineBusy = 1'b1;
        cmd(OP_READ_RESULT, ARG_NONE, 16'h0000);
        check(readResultStart, 1'b1);
        cmd(OP_WAIT, ARG_NONE, 16'h0000);
        repeat (4) @(negedge clock);
        check(cmdReady, 1'b0);
        engineBusy = 1'b0;
        repeat (4) @(negedge clock);
        check(cmdReady, 1'b1);
        $display("query and wait test done");
        final_report();
    end

    // Whole sequence needs a few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
endmodule : mch_command_handler_test
`default_nettype wire
